// ==== store_dev_model.sv ====
// Purpose: behavioural device on the far side of the store handshake line
// Assumes: line level is resolved by the bench; one clock used to count time
// Notes:   delays are counted in sys_clk cycles
`timescale 1ns/1ps
module store_dev_model #(
  parameter int DELAY_CYC = 10,
  parameter int STORE_CYC = 60
) (
  input  wire logic sys_clk,
  input  wire logic line,
  input  wire logic wr,
  output logic      pull_low,
  output int        stores
);
  int   st;
  int   cnt;
  logic pending;
  initial begin
    pull_low = 1'b0;
    stores = 0;
    st = 0;
    cnt = 0;
    pending = 1'b0;
  end
  // ----------------------------------------
  // request, delay, store, wait for release
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cnt <= cnt + 1;
    case (st)
      0: if (line === 1'b0) begin
        st <= 1;
        cnt <= 0;
      end else if (wr) pending <= 1'b1;
      1: if (cnt == DELAY_CYC) begin
        st <= pending ? 2 : 3;
        pull_low <= pending;
        cnt <= 0;
      end
      2: if (line === 1'b1) begin
        st <= 3;
        pull_low <= 1'b0;
      end else if (cnt == STORE_CYC) begin
        st <= 3;
        pull_low <= 1'b0;
        pending <= 1'b0;
        stores <= stores + 1;
      end
      default: if (line === 1'b1) st <= 0;
    endcase
  end
endmodule

// ==== store_hs_host.sv ====
// Purpose: host-side controller for the shared store/busy handshake line
// Assumes: open-drain line with external pull-up; one clock sys_clk
// Notes:   requests stores, watches busy, gates writes, optional suppression
//
// Function
// - a low from any party makes every device register a store request
// - shared lines are wired-AND; parties pull low, except a suppressing party that drives high
// - forcing the line high suppresses stores; device then abandons them
// - a suppressing party must hold the line high continuously
`timescale 1ns/1ps
module store_hs_host #(
  parameter int unsigned START_WAIT = store_hs_pkg::START_WAIT_CYC,
  parameter int unsigned STORE_MAX  = store_hs_pkg::STORE_MAX_CYC
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic                      store_req,
  input  wire logic                      suppress,
  input  wire logic                      hs_in,
  output logic                           hs_o,
  output logic                           hs_oe,
  output store_hs_pkg::hs_status_s       status
);

  // ------------------------------------------------------------
  // line synchroniser
  // ------------------------------------------------------------
  logic [1:0] sync_q;
  logic       hs_s3_q;
  logic       line_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_q  <= store_hs_pkg::SYNC_RESET;
      hs_s3_q <= 1'b1;
    end else begin
      sync_q  <= {sync_q[0], hs_in};
      hs_s3_q <= sync_q[1];
    end
  end

  // line level changes only once stages two and three agree
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_q <= 1'b1;
    end else if (sync_q[1] == hs_s3_q) begin
      line_q <= hs_s3_q;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  store_hs_pkg::hs_state_e     state_q;
  logic [store_hs_pkg::CNT_W-1:0] cnt_q;
  logic                        drive_low_q;
  logic                        drive_high_q;
  logic                        done_q;
  logic                        timeout_q;

  function automatic logic [store_hs_pkg::CNT_W-1:0] lim(input int unsigned v);
    lim = v[store_hs_pkg::CNT_W-1:0];
  endfunction

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= store_hs_pkg::ST_IDLE;
      cnt_q        <= '0;
      drive_low_q  <= 1'b0;
      drive_high_q <= 1'b0;
      done_q       <= 1'b0;
      timeout_q    <= 1'b0;
    end else if (suppress && (state_q != store_hs_pkg::ST_SUPPRESS)) begin
      // suppression wins in every state, even in the middle of a store
      cnt_q        <= '0;
      drive_low_q  <= 1'b0;
      drive_high_q <= 1'b1;
      done_q       <= 1'b0;
      timeout_q    <= 1'b0;
      state_q      <= store_hs_pkg::ST_SUPPRESS;
    end else begin
      done_q    <= 1'b0;
      timeout_q <= 1'b0;
      case (state_q)
        store_hs_pkg::ST_IDLE: begin
          cnt_q <= '0;
          if (store_req && line_q) begin
            drive_low_q <= 1'b1;
            state_q     <= store_hs_pkg::ST_REQUEST;
          end else if (!line_q) begin
            // another party requested: every device sees it, host tracks busy
            state_q <= store_hs_pkg::ST_WAIT_RELEASE;
          end
        end
        store_hs_pkg::ST_REQUEST: begin
          // hold the request through store_start_delay so the device registers it
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= lim(START_WAIT)) begin
            drive_low_q <= 1'b0;
            cnt_q       <= '0;
            state_q     <= store_hs_pkg::ST_WAIT_BUSY;
          end
        end
        store_hs_pkg::ST_WAIT_BUSY: begin
          // device busy keeps the line low; high means no store was needed
          // own release reaches line_q late, so the line is judged after settling
          cnt_q <= cnt_q + 1'b1;
          if ((cnt_q >= lim(store_hs_pkg::SETTLE_CYC)) && !line_q) begin
            cnt_q   <= '0;
            state_q <= store_hs_pkg::ST_WAIT_RELEASE;
          end else if (cnt_q >= lim(store_hs_pkg::NOBUSY_CYC)) begin
            done_q  <= 1'b1;
            state_q <= store_hs_pkg::ST_IDLE;
          end
        end
        store_hs_pkg::ST_WAIT_RELEASE: begin
          cnt_q <= cnt_q + 1'b1;
          if (line_q) begin
            done_q  <= 1'b1;
            state_q <= store_hs_pkg::ST_IDLE;
          end else if (cnt_q >= lim(STORE_MAX)) begin
            timeout_q <= 1'b1;
            state_q   <= store_hs_pkg::ST_IDLE;
          end
        end
        store_hs_pkg::ST_SUPPRESS: begin
          // leave once the line reads high, so an abandoned store is not seen as foreign
          if (!suppress && line_q) begin
            drive_high_q <= 1'b0;
            state_q      <= store_hs_pkg::ST_IDLE;
          end
        end
        default: begin
          drive_low_q  <= 1'b0;
          drive_high_q <= 1'b0;
          state_q      <= store_hs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hs_o   <= 1'b1;
      hs_oe  <= 1'b0;
      status <= '0;
    end else begin
      hs_o           <= drive_high_q;
      hs_oe          <= drive_low_q | drive_high_q;
      status.busy    <= (state_q != store_hs_pkg::ST_IDLE)
                        && (state_q != store_hs_pkg::ST_SUPPRESS);
      status.done    <= done_q;
      status.timeout <= timeout_q;
      // writes from the host are pointless while the line is low
      status.write_allowed <= line_q && !drive_low_q;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_no_low_while_suppress;
    @(posedge sys_clk) disable iff (!rstn)
      drive_high_q |-> !drive_low_q;
  endproperty
  a_no_low_while_suppress: assert property (p_no_low_while_suppress)
    else $error("low and high drive together");

  property p_pin_follows;
    @(posedge sys_clk) disable iff (!rstn)
      drive_low_q |=> (hs_oe && !hs_o);
  endproperty
  a_pin_follows: assert property (p_pin_follows)
    else $error("request not driven low on pin");

  property p_suppress_high;
    @(posedge sys_clk) disable iff (!rstn)
      (state_q == store_hs_pkg::ST_SUPPRESS) |=> (hs_oe && hs_o);
  endproperty
  a_suppress_high: assert property (p_suppress_high)
    else $error("suppress not driving high");

  property p_release_done;
    @(posedge sys_clk) disable iff (!rstn)
      (state_q == store_hs_pkg::ST_WAIT_RELEASE && line_q && !suppress) |=> done_q;
  endproperty
  a_release_done: assert property (p_release_done)
    else $error("release not reported");

  property p_suppress_any;
    @(posedge sys_clk) disable iff (!rstn)
      (suppress && state_q != store_hs_pkg::ST_SUPPRESS)
        |=> (state_q == store_hs_pkg::ST_SUPPRESS) && drive_high_q && !drive_low_q;
  endproperty
  a_suppress_any: assert property (p_suppress_any)
    else $error("suppress not taken at once");

  sequence s_req_taken;
    (state_q == store_hs_pkg::ST_IDLE) && store_req && line_q && !suppress;
  endsequence

  sequence s_pin_low;
    hs_oe && !hs_o;
  endsequence

  property p_req_to_pin;
    @(posedge sys_clk) disable iff (!rstn)
      s_req_taken |=> ##1 s_pin_low;
  endproperty
  a_req_to_pin: assert property (p_req_to_pin)
    else $error("request not on pin two cycles later");

  property p_write_gate;
    @(posedge sys_clk) disable iff (!rstn)
      !line_q |=> !status.write_allowed;
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("write allowed with line low");

  property p_busy_track;
    @(posedge sys_clk) disable iff (!rstn)
      (state_q == store_hs_pkg::ST_IDLE && !suppress && !store_req && !line_q)
        |=> state_q == store_hs_pkg::ST_WAIT_RELEASE;
  endproperty
  a_busy_track: assert property (p_busy_track)
    else $error("foreign request not tracked");

endmodule

// ==== store_hs_pkg.sv ====
// Purpose: shared constants and types for the store handshake host controller
// Assumes: 100 MHz system clock
// Notes:   times kept in their own units, cycle counts derived from them
package store_hs_pkg;

  localparam int unsigned CLK_MHZ = 100;
  // pull-down interval the device applies at the onset of a store, in ms
  localparam int unsigned PULLDOWN_MS = 20;
  localparam int unsigned PULLDOWN_CYC = PULLDOWN_MS * 1000 * CLK_MHZ;
  // default wait for the store to start, in us (longest wait rounds down)
  localparam int unsigned START_WAIT_US = 100;
  localparam int unsigned START_WAIT_CYC = START_WAIT_US * CLK_MHZ;
  // default bound on a whole store, in ms
  localparam int unsigned STORE_MAX_MS = 100;
  localparam int unsigned STORE_MAX_CYC = STORE_MAX_MS * 1000 * CLK_MHZ;
  // cycles before the host's own release can show on the synchronised line
  localparam int unsigned SETTLE_CYC = 6;
  // cycles in which a device store must show as a low line after the release
  localparam int unsigned NOBUSY_CYC = 16;
  localparam int unsigned CNT_W = 32;
  localparam logic [1:0] SYNC_RESET = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQUEST,
    ST_WAIT_BUSY,
    ST_WAIT_RELEASE,
    ST_SUPPRESS
  } hs_state_e;

  // handshake pin as two signals
  typedef struct packed {
    logic o;
    logic oe;
  } hs_drive_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic timeout;
    logic write_allowed;
  } hs_status_s;

endpackage

// ==== testbench.sv ====
// Purpose: self-checking bench for the store handshake host controller
// Assumes: shortened start wait of 20 cycles
// Notes:   the line is pulled up unless some party pulls it low; a host high drive overrides any low
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); error_cnt++; end end
module testbench;
  logic sys_clk = 1'b0, rstn = 1'b0, store_req = 1'b0, suppress = 1'b0, wr = 1'b0;
  logic hs_o, hs_oe, dev_low, line, sib_low = 1'b0;
  localparam int STORE_LIM = 2000;
  store_hs_pkg::hs_status_s status;
  int error_cnt = 0, n_compared = 0, exp_stores = 0, stores, seed = 32'h9613;
  bit pend = 0;
  always #5 sys_clk = ~sys_clk;
  assign line = (hs_oe && hs_o) ? 1'b1 : !((hs_oe && !hs_o) || dev_low || sib_low);
  store_hs_host #(.START_WAIT(20), .STORE_MAX(STORE_LIM)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .store_req(store_req), .suppress(suppress), .hs_in(line), .hs_o(hs_o), .hs_oe(hs_oe),
    .status(status));
  store_dev_model #(.DELAY_CYC(10), .STORE_CYC(60)) dev (.sys_clk(sys_clk), .line(line),
    .wr(wr), .pull_low(dev_low), .stores(stores));
  // ----------------------------------------
  // closing report
  // ----------------------------------------
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // one hardware store request
  // ----------------------------------------
  // ----------------------------------------
  // wait for the end of a store and check it
  // ----------------------------------------
  task automatic finish_store(input string what);
    bit seen;
    seen = 0;
    for (int i = 0; i < 400 && !seen; i++) begin
      @(posedge sys_clk);
      #1;
      seen = (status.done === 1'b1);
    end
    `CHK("done_seen", 1'b1, seen)
    if (!seen) give_verdict();
    if (pend) exp_stores++;
    pend = 0;
    `CHK("stores", exp_stores, stores)
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("released", 1'b0, hs_oe)
    `CHK("write_open", 1'b1, status.write_allowed)
    $display("test %s ended", what);
  endtask
  task automatic do_store(input bit w);
    if (w) begin
      @(posedge sys_clk) wr <= 1'b1;
      @(posedge sys_clk) wr <= 1'b0;
      pend = 1;
    end
    @(posedge sys_clk) store_req <= 1'b1;
    @(posedge sys_clk) store_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("drive_low", 2'b10, {hs_oe, hs_o})
    `CHK("busy", 1'b1, status.busy)
    `CHK("write_blocked", 1'b0, status.write_allowed)
    if (w) finish_store("store after write");
    else finish_store("store without write");
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    bit w;
    bit seen;
    int cyc;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK("reset_status", 4'h0, status)
    `CHK("reset_oe", 1'b0, hs_oe)
    @(posedge sys_clk) rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    do_store(1'b1);
    do_store(1'b0);
    for (int k = 0; k < 6; k++) begin
      w = $random(seed);
      repeat (($random(seed) & 7) + 1) @(posedge sys_clk);
      do_store(w);
    end
    @(posedge sys_clk) wr <= 1'b1;
    suppress <= 1'b1;
    store_req <= 1'b1;
    @(posedge sys_clk) wr <= 1'b0;
    pend = 1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("suppress_drive", 2'b11, {hs_oe, hs_o})
    `CHK("suppress_idle", 1'b0, status.busy)
    @(posedge sys_clk) suppress <= 1'b0;
    store_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
    $display("test suppress ended");
    do_store(1'b0);
    // suppress while the device stores: it gives the store up
    @(posedge sys_clk) wr <= 1'b1;
    @(posedge sys_clk) wr <= 1'b0;
    pend = 1;
    @(posedge sys_clk) store_req <= 1'b1;
    @(posedge sys_clk) store_req <= 1'b0;
    repeat (40) @(posedge sys_clk);
    suppress <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("abort_drive", 2'b11, {hs_oe, hs_o})
    `CHK("abort_dev_release", 1'b0, dev_low)
    @(posedge sys_clk) suppress <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("abort_stores", exp_stores, stores)
    `CHK("abort_released", 1'b0, hs_oe)
    $display("test abort ended");
    do_store(1'b0);
    // a sibling device pulls the shared line low
    @(posedge sys_clk) wr <= 1'b1;
    @(posedge sys_clk) wr <= 1'b0;
    pend = 1;
    sib_low <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("foreign_busy", 1'b1, status.busy)
    `CHK("foreign_no_drive", 1'b0, hs_oe)
    `CHK("foreign_write_blocked", 1'b0, status.write_allowed)
    repeat (12) @(posedge sys_clk);
    sib_low <= 1'b0;
    finish_store("foreign request");
    // the line stays low past the store bound
    @(posedge sys_clk) sib_low <= 1'b1;
    cyc = 0;
    seen = 0;
    while (cyc < STORE_LIM + 100 && !seen) begin
      @(posedge sys_clk);
      #1;
      cyc++;
      seen = (status.timeout === 1'b1);
    end
    `CHK("timeout_seen", 1'b1, seen)
    `CHK("timeout_not_early", 1'b1, cyc > STORE_LIM)
    @(posedge sys_clk) sib_low <= 1'b0;
    finish_store("timeout");
    give_verdict();
  end
endmodule
